// ===== rtl/arx_label_store.sv
// Purpose: Eight stored labels with readback and match against an incoming label
// Assumes: Writes come one at a time from the host port
// Notes: Match is combinational on the compare input
`timescale 1ns/1ps

module arx_label_store (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Load and readback
    input wire logic wr_en_in,
    input wire logic [2:0] wr_idx_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [2:0] rd_idx_in,
    output logic [7:0] rd_data_out,
    // Compare
    input wire logic [7:0] cmp_data_in,
    output logic match_out
);
    import arx_pkg::*;

    typedef struct packed {
        logic [ARX_NUM_LABELS-1:0][7:0] lab;
    } arx_lbl_t;

    arx_lbl_t r_reg, r_next;
    logic [ARX_NUM_LABELS-1:0] hit;

    always_comb begin
        r_next = r_reg;
        if (wr_en_in) begin
            r_next.lab[wr_idx_in] = wr_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < ARX_NUM_LABELS; i++) begin : g_cmp
            assign hit[i] = (r_reg.lab[i] == cmp_data_in);
        end
    endgenerate

    assign match_out = |hit;
    assign rd_data_out = r_reg.lab[rd_idx_in];

    property p_lbl_load;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        wr_en_in |=> (r_reg.lab[$past(wr_idx_in)] == $past(wr_data_in));
    endproperty
    a_lbl_load: assert property (p_lbl_load)
        else $error("label write not stored");
endmodule

// ===== rtl/arx_line_decoder.sv
// Purpose: Samples the zero and one lines on each bit-clock rising edge
// Assumes: Bit clock is four times the bit rate and sampled as a level
// Notes: A bit counts only after a null has been seen, so a reset mid-bit is safe
`timescale 1ns/1ps

module arx_line_decoder (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Line side
    input wire logic sample_clk_in,
    input wire logic zero_line_in,
    input wire logic one_line_in,
    input wire logic enable_in,
    // Decoded events
    output logic bit_valid_out,
    output logic bit_value_out,
    output logic both_high_out,
    output logic gap_out
);
    import arx_pkg::*;

    typedef struct packed {
        logic clk_prev;
        logic was_null;
        logic [3:0] null_cnt;
        logic bit_valid;
        logic bit_value;
        logic both_high;
    } arx_dec_t;

    arx_dec_t r_reg, r_next;

    always_comb begin
        r_next = r_reg;
        r_next.bit_valid = 1'b0;
        r_next.both_high = 1'b0;
        r_next.clk_prev = sample_clk_in;
        if (!enable_in) begin
            r_next.null_cnt = 4'h0;
            r_next.was_null = 1'b0;
        end else if (sample_clk_in && !r_reg.clk_prev) begin
            if (zero_line_in && one_line_in) begin
                r_next.both_high = 1'b1;
                r_next.was_null = 1'b0;
                r_next.null_cnt = 4'h0;
            end else if (zero_line_in || one_line_in) begin
                r_next.null_cnt = 4'h0;
                r_next.was_null = 1'b0;
                if (r_reg.was_null) begin
                    r_next.bit_valid = 1'b1;
                    r_next.bit_value = one_line_in;
                end
            end else begin
                r_next.was_null = 1'b1;
                if (r_reg.null_cnt != ARX_GAP_SAMPLES) begin
                    r_next.null_cnt = r_reg.null_cnt + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign bit_valid_out = r_reg.bit_valid;
    assign bit_value_out = r_reg.bit_value;
    assign both_high_out = r_reg.both_high;
    assign gap_out = (r_reg.null_cnt == ARX_GAP_SAMPLES);

    property p_no_bit_in_gap;
        @(posedge clk_sys_in) disable iff (!rst_n_in)
        gap_out |-> !bit_valid_out;
    endproperty
    a_no_bit_in_gap: assert property (p_no_bit_in_gap)
        else $error("bit decoded while gap is reported");
endmodule

// ===== rtl/arx_pkg.sv
// Purpose: Shared constants and types of the serial word receiver
// Assumes: 100 MHz system clock, host strobes synchronous to it
// Notes: Control and status bit positions are those of the 8-bit host port

package arx_pkg;
    // ========================================================
    // Control word
    localparam logic [7:0] ARX_CTRL_RESET = 8'h25;
    localparam int ARX_CR_LBL_READ = 1;
    localparam int ARX_CR_RX_EN = 2;
    localparam int ARX_CR_BLOCK = 3;
    localparam int ARX_CR_SELF_TEST = 4;
    localparam int ARX_CR_PARITY = 5;
    localparam int ARX_CR_LBL_MATCH = 7;
    // ========================================================
    // Status word
    localparam int ARX_SR_READY = 1;
    localparam int ARX_SR_PARITY = 3;
    localparam int ARX_SR_OVW = 4;
    localparam int ARX_SR_FRAME = 5;
    localparam int ARX_SR_FIRST = 6;
    // ========================================================
    // Word geometry and counts
    localparam logic [5:0] ARX_LAST_BIT = 6'h1f;
    localparam logic [2:0] ARX_BYTE_END = 3'h7;
    localparam logic [1:0] ARX_LAST_BYTE = 2'h3;
    localparam logic [3:0] ARX_GAP_SAMPLES = 4'hc;
    localparam logic [3:0] ARX_LABEL_COUNT = 4'h8;
    localparam int ARX_NUM_LABELS = 8;
    // ========================================================
    // Receiver states
    typedef enum logic [1:0] {
        ARX_WAIT_GAP = 2'b00,
        ARX_IDLE = 2'b01,
        ARX_RECV = 2'b10,
        ARX_TAIL = 2'b11
    } arx_rx_state_t;
endpackage

// ===== rtl/arx_top.sv
// Purpose: Receive side of a two-line serial word receiver with 8-bit host port
// Assumes: Host strobes, pins and bit clocks are levels synchronous to clk_sys_in
// Notes: Host access acts on the falling edge of the write or read strobe
`timescale 1ns/1ps

//Contract
// - Feature pin low forbids 32-bit and label modes
// - Readback bit rise returns eight stored labels
// - Ready-block hides one word, then self-clears
// - Parity bit and pin select mode jointly
// - Label-match bit enables recognition when pin high
// - Hard init loads control 0x25, clears state
// - First word accepted only after word gap
// - 8-bit mode: ready per good byte
// - 32-bit mode: ready after good whole word
// - Unmatched label keeps ready low
// - First-byte flag marks first byte or word
// - First-byte flag ignores ready-block bit
// - Zero line, one line, both low null
// - Status shows data ready
// - Even parity sets parity error
// - Unread data overwritten sets overwrite bit
// - Not exactly 32 good bits: framing error
// - Status first-byte bit equals pin
// - Self test loops transmitter into receiver
// - Both high, short word, long word: error
// - Error pin; cleared by init or status read
module arx_top (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Hardware control pins
    input wire logic hard_init_pin_in,
    input wire logic feature_select_pin_in,
    // Receive line
    input wire logic rx_bit_clock_in,
    input wire logic rx_zero_line_in,
    input wire logic rx_one_line_in,
    // Transmitter loopback for self test
    input wire logic tx_bit_clock_in,
    input wire logic tx_zero_line_in,
    input wire logic tx_one_line_in,
    // Host port
    input wire logic cs_n_in,
    input wire logic we_n_in,
    input wire logic re_n_in,
    input wire logic ctrl_sel_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    // Flags
    output logic rx_word_ready_out,
    output logic first_byte_flag_out,
    output logic error_pin_out
);
    import arx_pkg::*;

    typedef struct packed {
        arx_rx_state_t state;
        logic [7:0] ctrl;
        logic [5:0] bit_cnt;
        logic [7:0] byte_sr;
        logic [31:0] word_sr;
        logic par_acc;
        logic ignore;
        logic [7:0] byte_buf;
        logic [31:0] word_buf;
        logic [1:0] rd_idx;
        logic ready;
        logic first_byte;
        logic par_err;
        logic ovw_err;
        logic frm_err;
        logic [3:0] lbl_rd_cnt;
        logic [3:0] lbl_ld_cnt;
        logic [7:0] dout;
        logic we_prev;
        logic re_prev;
    } arx_core_t;

    localparam arx_core_t ARX_CORE_RESET = '{state: ARX_WAIT_GAP, ctrl: ARX_CTRL_RESET,
        we_prev: 1'b1, re_prev: 1'b1, default: '0};

    // ========================================================
    // Reset release
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    arx_core_t r_reg, r_next;

    // ========================================================
    // Mode decode
    logic mode32, parity_on, lbl_active, rx_en, self_test;
    assign mode32 = feature_select_pin_in && !r_reg.ctrl[ARX_CR_PARITY];
    assign parity_on = feature_select_pin_in || r_reg.ctrl[ARX_CR_PARITY];
    assign lbl_active = feature_select_pin_in && r_reg.ctrl[ARX_CR_LBL_MATCH];
    assign rx_en = r_reg.ctrl[ARX_CR_RX_EN];
    assign self_test = r_reg.ctrl[ARX_CR_SELF_TEST];

    // ========================================================
    // Line front end
    logic smp_clk, smp_zero, smp_one, dec_en;
    logic bit_valid, bit_value, both_high, gap;
    assign smp_clk = self_test ? tx_bit_clock_in : rx_bit_clock_in;
    assign smp_zero = self_test ? tx_zero_line_in : rx_zero_line_in;
    assign smp_one = self_test ? tx_one_line_in : rx_one_line_in;
    assign dec_en = rx_en && !hard_init_pin_in;

    arx_line_decoder u_dec (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n),
        .sample_clk_in(smp_clk),
        .zero_line_in(smp_zero),
        .one_line_in(smp_one),
        .enable_in(dec_en),
        .bit_valid_out(bit_valid),
        .bit_value_out(bit_value),
        .both_high_out(both_high),
        .gap_out(gap)
    );

    // ========================================================
    // Host strobes and label store
    logic wr_stb, rd_stb, ctrl_wr, data_wr, stat_rd, data_rd;
    logic lbl_wr, lbl_hit;
    logic [2:0] lbl_wr_idx, lbl_rd_idx;
    logic [7:0] lbl_rd_data, byte_nx, status_word;

    assign wr_stb = !cs_n_in && !we_n_in && r_reg.we_prev;
    assign rd_stb = !cs_n_in && !re_n_in && r_reg.re_prev;
    assign ctrl_wr = wr_stb && ctrl_sel_in;
    assign data_wr = wr_stb && !ctrl_sel_in;
    assign stat_rd = rd_stb && ctrl_sel_in;
    assign data_rd = rd_stb && !ctrl_sel_in;
    assign lbl_wr = data_wr && (r_reg.lbl_ld_cnt != 4'h0);
    assign lbl_wr_idx = 3'(ARX_LABEL_COUNT - r_reg.lbl_ld_cnt);
    assign lbl_rd_idx = 3'(ARX_LABEL_COUNT - r_reg.lbl_rd_cnt);
    assign byte_nx = {bit_value, r_reg.byte_sr[7:1]};

    arx_label_store u_lbl (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n),
        .wr_en_in(lbl_wr),
        .wr_idx_in(lbl_wr_idx),
        .wr_data_in(data_in),
        .rd_idx_in(lbl_rd_idx),
        .rd_data_out(lbl_rd_data),
        .cmp_data_in(byte_nx),
        .match_out(lbl_hit)
    );

    always_comb begin
        status_word = 8'h00;
        status_word[ARX_SR_READY] = r_reg.ready;
        status_word[ARX_SR_PARITY] = r_reg.par_err;
        status_word[ARX_SR_OVW] = r_reg.ovw_err;
        status_word[ARX_SR_FRAME] = r_reg.frm_err;
        status_word[ARX_SR_FIRST] = r_reg.first_byte;
    end

    // ========================================================
    // Core next state
    logic is_idle, par_nx, ign_nx, bad_par;
    logic [5:0] cnt;

    always_comb begin
        r_next = r_reg;
        is_idle = (r_reg.state == ARX_IDLE);
        cnt = is_idle ? 6'h00 : r_reg.bit_cnt;
        par_nx = (is_idle ? 1'b0 : r_reg.par_acc) ^ bit_value;
        ign_nx = is_idle ? 1'b0 : r_reg.ignore;
        bad_par = parity_on && !par_nx;
        r_next.we_prev = we_n_in || cs_n_in;
        r_next.re_prev = re_n_in || cs_n_in;
        // Host writes
        if (ctrl_wr) begin
            r_next.ctrl = data_in;
            if (feature_select_pin_in && data_in[ARX_CR_LBL_READ]
                && !r_reg.ctrl[ARX_CR_LBL_READ]) begin
                r_next.lbl_rd_cnt = ARX_LABEL_COUNT;
            end
            if (data_in[ARX_CR_LBL_MATCH] && !r_reg.ctrl[ARX_CR_LBL_MATCH]) begin
                r_next.lbl_ld_cnt = ARX_LABEL_COUNT;
            end
        end
        if (lbl_wr) begin
            r_next.lbl_ld_cnt = r_reg.lbl_ld_cnt - 4'h1;
        end
        // Host reads
        if (stat_rd) begin
            r_next.dout = status_word;
            r_next.par_err = 1'b0;
            r_next.ovw_err = 1'b0;
            r_next.frm_err = 1'b0;
        end else if (data_rd) begin
            if (r_reg.lbl_rd_cnt != 4'h0) begin
                r_next.dout = lbl_rd_data;
                r_next.lbl_rd_cnt = r_reg.lbl_rd_cnt - 4'h1;
            end else if (mode32) begin
                r_next.dout = r_reg.word_buf[8*r_reg.rd_idx +: 8];
                r_next.first_byte = 1'b0;
                if (r_reg.ready) begin
                    r_next.rd_idx = r_reg.rd_idx + 2'h1;
                    if (r_reg.rd_idx == ARX_LAST_BYTE) begin
                        r_next.ready = 1'b0;
                    end
                end
            end else begin
                r_next.dout = r_reg.byte_buf;
                r_next.ready = 1'b0;
                r_next.first_byte = 1'b0;
            end
        end
        // Reception; error sets come after the read clear so they win
        if (!rx_en) begin
            r_next.state = ARX_WAIT_GAP;
        end else begin
            case (r_reg.state)
                ARX_WAIT_GAP: begin
                    if (gap) begin
                        r_next.state = ARX_IDLE;
                    end
                end
                ARX_IDLE, ARX_RECV: begin
                    if (both_high) begin
                        r_next.frm_err = 1'b1;
                        r_next.state = ARX_WAIT_GAP;
                    end else if (r_reg.state == ARX_RECV && gap) begin
                        r_next.frm_err = 1'b1;
                        r_next.state = ARX_IDLE;
                    end else if (bit_valid) begin
                        r_next.state = ARX_RECV;
                        r_next.bit_cnt = cnt + 6'h01;
                        r_next.par_acc = par_nx;
                        r_next.byte_sr = byte_nx;
                        r_next.word_sr = {bit_value, r_reg.word_sr[31:1]};
                        if (cnt == 6'h07 && lbl_active && !lbl_hit) begin
                            ign_nx = 1'b1;
                        end
                        r_next.ignore = ign_nx;
                        if (cnt[2:0] == ARX_BYTE_END && !mode32 && !ign_nx
                            && !(cnt == ARX_LAST_BIT && bad_par)) begin
                            r_next.ovw_err = r_next.ovw_err || r_next.ready;
                            r_next.byte_buf = byte_nx;
                            r_next.ready = r_next.ready || !r_reg.ctrl[ARX_CR_BLOCK];
                            r_next.first_byte = (cnt[5:3] == 3'h0);
                        end
                        if (cnt == ARX_LAST_BIT) begin
                            r_next.state = ARX_TAIL;
                            r_next.par_err = r_next.par_err || bad_par;
                            if (!ctrl_wr) begin
                                r_next.ctrl[ARX_CR_BLOCK] = 1'b0;
                            end
                            if (mode32 && !ign_nx && !bad_par) begin
                                r_next.ovw_err = r_next.ovw_err || r_next.ready;
                                r_next.word_buf = {bit_value, r_reg.word_sr[31:1]};
                                r_next.rd_idx = 2'h0;
                                r_next.ready = !r_reg.ctrl[ARX_CR_BLOCK];
                                r_next.first_byte = 1'b1;
                            end
                        end
                    end
                end
                ARX_TAIL: begin
                    if (bit_valid || both_high) begin
                        r_next.frm_err = 1'b1;
                        r_next.state = ARX_WAIT_GAP;
                    end else if (gap) begin
                        r_next.state = ARX_IDLE;
                    end
                end
                default: begin
                    r_next.state = ARX_WAIT_GAP;
                end
            endcase
        end
        if (hard_init_pin_in) begin
            r_next = ARX_CORE_RESET;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= ARX_CORE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ========================================================
    // Outputs
    assign data_out = r_reg.dout;
    assign data_oe_out = !cs_n_in && !re_n_in;
    assign rx_word_ready_out = r_reg.ready;
    assign first_byte_flag_out = r_reg.first_byte;
    assign error_pin_out = r_reg.par_err || r_reg.ovw_err || r_reg.frm_err;

    // ========================================================
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    property p_no_ext_modes;
        !feature_select_pin_in |-> !mode32 && !lbl_active;
    endproperty
    a_no_ext_modes: assert property (p_no_ext_modes)
        else $error("extended or label mode with feature pin low");

    property p_init_ctrl;
        hard_init_pin_in |=> r_reg.ctrl == ARX_CTRL_RESET && !rx_word_ready_out;
    endproperty
    a_init_ctrl: assert property (p_init_ctrl)
        else $error("hard init did not load control word");

    sequence s_last_bit;
        rx_en && !hard_init_pin_in && bit_valid && !both_high
            && r_reg.state == ARX_RECV && r_reg.bit_cnt == ARX_LAST_BIT;
    endsequence

    property p_block_clear;
        s_last_bit ##0 !ctrl_wr |=> !r_reg.ctrl[ARX_CR_BLOCK];
    endproperty
    a_block_clear: assert property (p_block_clear)
        else $error("ready-block bit not cleared at word end");

    property p_parity_err;
        s_last_bit ##0 (parity_on && !par_nx) |=> r_reg.par_err && error_pin_out;
    endproperty
    a_parity_err: assert property (p_parity_err)
        else $error("even parity not flagged");

    property p_long_word;
        (rx_en && !hard_init_pin_in && r_reg.state == ARX_TAIL && bit_valid)
            |=> r_reg.frm_err ##1 (error_pin_out || $past(stat_rd) || $past(hard_init_pin_in));
    endproperty
    a_long_word: assert property (p_long_word)
        else $error("bit after 32 not flagged");

    property p_disabled;
        !rx_en && !hard_init_pin_in |=> r_reg.state == ARX_WAIT_GAP;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("receiver active while disabled");

    property p_status_ready;
        stat_rd && !hard_init_pin_in |=> data_out[ARX_SR_READY] == $past(rx_word_ready_out)
            && data_out[ARX_SR_FIRST] == $past(first_byte_flag_out);
    endproperty
    a_status_ready: assert property (p_status_ready)
        else $error("status bits disagree with pins");

    property p_err_clear;
        stat_rd && !hard_init_pin_in && !both_high && !bit_valid && !gap
            |=> !error_pin_out;
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("status read did not clear errors");

    property p_label_read;
        $rose(r_reg.lbl_rd_cnt == ARX_LABEL_COUNT) |-> $past(feature_select_pin_in);
    endproperty
    a_label_read: assert property (p_label_read)
        else $error("label readback armed with feature pin low");
endmodule

// ===== verification/arx_line_model.sv
// Purpose: Line receiver model driving bit clock, zero line and one line
// Assumes: One bit clock period is 8 system clocks
// Notes: Lines change while the bit clock is low; both low is the null state
`timescale 1ns/1ps

module arx_line_model (
    // Clock
    input wire logic clk_sys_in,
    // Line side
    output logic bit_clk_out,
    output logic zero_out,
    output logic one_out
);
    initial begin
        bit_clk_out = 1'b0;
        zero_out = 1'b0;
        one_out = 1'b0;
    end
    // ====
    // One sample period
    task automatic tick(input logic z, input logic o);
        @(posedge clk_sys_in);
        #1;
        bit_clk_out = 1'b0;
        zero_out = z;
        one_out = o;
        repeat (4) @(posedge clk_sys_in);
        #1;
        bit_clk_out = 1'b1;
        repeat (3) @(posedge clk_sys_in);
    endtask
    // ====
    // Sends n bits, LSB first, then a word gap; bits past 31 wrap to bit 0
    task automatic send_word(input logic [31:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            tick(!w[i % 32], w[i % 32]);
            tick(!w[i % 32], w[i % 32]);
            tick(1'b0, 1'b0);
            tick(1'b0, 1'b0);
        end
        repeat (14) tick(1'b0, 1'b0);
    endtask
endmodule

// ===== verification/tb.sv
// Purpose: Host-port bench for the serial word receiver
// Assumes: Host strobes held two cycles, released one cycle
// Notes: Transmitter loopback inputs are held idle
`timescale 1ns/1ps

module tb;
    import arx_pkg::*;
    logic clk_sys_in, reset_n_in, hard_init_pin_in, feature_select_pin_in;
    logic cs_n_in, we_n_in, re_n_in, ctrl_sel_in, data_oe_out;
    logic [7:0] data_in, data_out, q;
    logic rx_word_ready_out, first_byte_flag_out, error_pin_out, bclk, zl, ol;
    int mismatches = 0;
    int cmp_count = 0;
    // Control, word byte, expected status
    logic [23:0] rows [5] = '{24'h25a712, 24'h25a61a, 24'h84a612, 24'h00a700, 24'h14a700};

    arx_line_model u_line (.clk_sys_in(clk_sys_in), .bit_clk_out(bclk), .zero_out(zl),
        .one_out(ol));
    arx_top uut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .hard_init_pin_in(hard_init_pin_in), .feature_select_pin_in(feature_select_pin_in),
        .rx_bit_clock_in(bclk), .rx_zero_line_in(zl), .rx_one_line_in(ol),
        .tx_bit_clock_in(1'b0), .tx_zero_line_in(1'b0), .tx_one_line_in(1'b0),
        .cs_n_in(cs_n_in), .we_n_in(we_n_in), .re_n_in(re_n_in), .ctrl_sel_in(ctrl_sel_in),
        .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
        .rx_word_ready_out(rx_word_ready_out), .first_byte_flag_out(first_byte_flag_out),
        .error_pin_out(error_pin_out));

    // ====
    // Host access, op is {ctrl_sel, write}
    task automatic host(input logic [1:0] op, input logic [7:0] d);
        @(posedge clk_sys_in);
        #1;
        cs_n_in = 1'b0;
        ctrl_sel_in = op[1];
        data_in = d;
        we_n_in = !op[0];
        re_n_in = op[0];
        repeat (2) @(posedge clk_sys_in);
        #1;
        q = data_out;
        cs_n_in = 1'b1;
        we_n_in = 1'b1;
        re_n_in = 1'b1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_word(input logic [7:0] b0);
        for (int i = 0; i < 4; i++) begin
            host(2'b00, 8'h00);
            check(q, (i == 0) ? b0 : 8'h00);
        end
        check({7'h0, rx_word_ready_out}, 8'h00);
    endtask
    task automatic wrap_up;
        $display("compares %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        mismatches++;
        wrap_up();
    end
    initial begin
        reset_n_in = 1'b0;
        hard_init_pin_in = 1'b0;
        feature_select_pin_in = 1'b0;
        cs_n_in = 1'b1;
        we_n_in = 1'b1;
        re_n_in = 1'b1;
        ctrl_sel_in = 1'b0;
        data_in = 8'h00;
        repeat (20) @(posedge clk_sys_in);
        #1;
        reset_n_in = 1'b1;
        repeat (3) @(posedge clk_sys_in);
        u_line.send_word(32'ha7, 32);
        host(2'b10, 8'h00);
        check(q, 8'h00);
        $display("test gap done");
        feature_select_pin_in = 1'b1;
        host(2'b11, 8'h04);
        u_line.send_word(32'ha7, 32);
        check({7'h0, first_byte_flag_out}, 8'h01);
        host(2'b10, 8'h00);
        check(q, 8'h42);
        rd_word(8'ha7);
        host(2'b11, 8'h0c);
        u_line.send_word(32'ha7, 32);
        check({7'h0, rx_word_ready_out}, 8'h00);
        check({7'h0, first_byte_flag_out}, 8'h01);
        u_line.send_word(32'ha7, 32);
        check({7'h0, rx_word_ready_out}, 8'h01);
        rd_word(8'ha7);
        u_line.send_word(32'ha7, 20);
        check({7'h0, error_pin_out}, 8'h01);
        host(2'b10, 8'h00);
        check(q, 8'h20);
        check({7'h0, error_pin_out}, 8'h00);
        $display("test wide done");
        u_line.send_word(32'ha7, 33);
        check({7'h0, error_pin_out}, 8'h01);
        host(2'b10, 8'h00);
        check(q, 8'h62);
        rd_word(8'ha7);
        host(2'b11, 8'h84);
        for (int i = 0; i < 8; i++) host(2'b01, 8'h10 + 8'(i));
        u_line.send_word(32'ha7, 32);
        check({7'h0, rx_word_ready_out}, 8'h00);
        host(2'b11, 8'h86);
        for (int i = 0; i < 8; i++) begin
            host(2'b00, 8'h00);
            check(q, 8'h10 + 8'(i));
        end
        u_line.send_word(32'h13, 32);
        check({7'h0, rx_word_ready_out}, 8'h01);
        $display("test label done");
        @(posedge clk_sys_in);
        #1;
        hard_init_pin_in = 1'b1;
        repeat (2) @(posedge clk_sys_in);
        #1;
        hard_init_pin_in = 1'b0;
        check({6'h0, rx_word_ready_out, first_byte_flag_out}, 8'h00);
        u_line.send_word(32'ha7, 32);
        host(2'b10, 8'h00);
        check(q, 8'h00);
        feature_select_pin_in = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (i > 0) begin
                host(2'b11, rows[i][23:16]);
            end
            repeat (2) u_line.send_word({24'h0, rows[i][15:8]}, 32);
            check({7'h0, error_pin_out}, {7'h0, |(rows[i][7:0] & 8'h38)});
            host(2'b10, 8'h00);
            check(q, rows[i][7:0]);
            host(2'b00, 8'h00);
            check({7'h0, rx_word_ready_out}, 8'h00);
        end
        $display("test modes done");
        wrap_up();
    end
endmodule
